// ### design/i2csh_pkg.sv
package i2csh_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [4:0]  TEN_BIT_HEAD  = 5'h1E;
  localparam logic [7:0]  ADDR_RESET    = 8'h00;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic        RELEASE_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_TXACK
  } i2csh_state_t;
endpackage

// ### design/i2csh_slave.sv
`timescale 1ns/1ps
`default_nettype none
module i2csh_slave (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_scl_o,
  output logic                             o_scl_oe,
  output logic                             o_sda_o,
  output logic                             o_sda_oe,
  input  wire logic                        i_ten_bit_mode,
  input  wire logic                        i_address_hold_enable,
  input  wire logic                        i_data_hold_enable,
  input  wire logic                        i_stretch_enable,
  input  wire logic                        i_slave_collision_detect_enable,
  input  wire logic                        i_stop_int_enable,
  input  wire logic                        i_ack_value_select,
  input  wire logic                        i_clock_release_set,
  input  wire logic                        i_port_interrupt_clear,
  input  wire logic                        i_collision_clear,
  input  wire logic                        i_overflow_clear,
  input  wire logic                        i_stop_clear,
  input  wire logic                        i_buffer_read,
  input  wire logic                        i_buffer_write,
  input  wire logic [i2csh_pkg::BYTE_W-1:0] i_buffer_wdata,
  input  wire logic                        i_address_write,
  input  wire logic [i2csh_pkg::BYTE_W-1:0] i_address_wdata,
  output logic [i2csh_pkg::BYTE_W-1:0]     o_transfer_buffer,
  output logic [i2csh_pkg::BYTE_W-1:0]     o_slave_address_register,
  output logic                             o_buffer_full_flag,
  output logic                             o_receive_overflow_flag,
  output logic                             o_port_interrupt_flag,
  output logic                             o_clock_release_bit,
  output logic                             o_ack_time_flag,
  output logic                             o_ack_received_status,
  output logic                             o_address_update_flag,
  output logic                             o_collision_interrupt_flag,
  output logic                             o_read_write_status,
  output logic                             o_stop_detected
);
  import i2csh_pkg::*;

  logic [2:0]        scl_sync_q;
  logic [2:0]        sda_sync_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  i2csh_state_t      state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [BYTE_W-1:0] rx_sr_q;
  logic [BYTE_W-1:0] tx_sr_q;
  logic [BYTE_W-1:0] buf_q;
  logic [BYTE_W-1:0] addr_q;
  logic              bf_q;
  logic              ov_q;
  logic              pif_q;
  logic              ckp_q;
  logic              ackt_q;
  logic              ackst_q;
  logic              ua_q;
  logic              bcl_q;
  logic              rw_q;
  logic              stop_q;
  logic              scl_oe_q;
  logic              sda_oe_q;
  logic              ack_q;
  logic              hold_q;
  logic              is_addr_q;
  logic              go_read_q;
  logic              low_miss_q;
  logic              lo_expect_q;
  logic              ten_ok_q;
  logic              eighth_fall;
  logic              ninth_fall;
  logic              m7;
  logic              m10_hi;
  logic              m10_lo;
  logic              addr_match;
  logic              byte_rw;
  logic              busy_nack;
  logic              hold_now;
  logic              hw_set_if;
  logic              hw_clr_ckp;
  logic              load_buf;
  logic              tx_coll;

  // Two-flop synchronisers, third stage gives the previous synced value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], i_scl};
      sda_sync_q <= {sda_sync_q[1:0], i_sda};
    end
  end

  // Bus events from synced samples only
  assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
  assign start_det = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
  assign stop_det  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

  assign eighth_fall = scl_fall & (state_q == ST_ADDR || state_q == ST_RX)
                       & (cnt_q == BITS_PER_BYTE);
  assign ninth_fall  = scl_fall & (state_q == ST_ACK);

  // Address decode on the fully shifted byte
  assign byte_rw   = rx_sr_q[0];
  assign m7        = rx_sr_q[7:1] == addr_q[7:1];
  assign m10_hi    = (rx_sr_q[7:3] == TEN_BIT_HEAD) & (rx_sr_q[2:1] == addr_q[2:1]);
  assign m10_lo    = rx_sr_q == addr_q;
  assign addr_match = !i_ten_bit_mode ? m7 :
                      lo_expect_q ? m10_lo :
                      (m10_hi & (!byte_rw | ten_ok_q));
  assign busy_nack = bf_q | ov_q;
  assign hold_now  = (state_q == ST_ADDR) ? i_address_hold_enable : i_data_hold_enable;
  assign tx_coll   = scl_rise & (state_q == ST_TX) & tx_sr_q[BYTE_W-1] & ~sda_sync_q[1]
                     & i_slave_collision_detect_enable;

  // Byte accepted into the buffer at the eighth fall
  assign load_buf = eighth_fall & !busy_nack & ((state_q == ST_RX) | addr_match);

  // Hardware interrupt sources
  always_comb begin
    hw_set_if = 1'b0;
    if (eighth_fall & load_buf & hold_now)
      hw_set_if = 1'b1;
    if (ninth_fall & (ack_q | low_miss_q))
      hw_set_if = 1'b1;
    if (scl_fall & (state_q == ST_TXACK))
      hw_set_if = 1'b1;
    if (stop_det & i_stop_int_enable & (state_q != ST_IDLE))
      hw_set_if = 1'b1;
  end

  // Hardware clears of the release bit
  always_comb begin
    hw_clr_ckp = 1'b0;
    if (eighth_fall & load_buf & hold_now)
      hw_clr_ckp = 1'b1;
    if (ninth_fall & ack_q & !low_miss_q & (go_read_q | i_stretch_enable))
      hw_clr_ckp = 1'b1;
    if (scl_fall & (state_q == ST_TXACK) & !sda_sync_q[2])
      hw_clr_ckp = 1'b1;
  end

  // Main transfer sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      rx_sr_q     <= BYTE_RESET;
      ack_q       <= 1'b0;
      hold_q      <= 1'b0;
      is_addr_q   <= 1'b0;
      go_read_q   <= 1'b0;
      low_miss_q  <= 1'b0;
      lo_expect_q <= 1'b0;
      ten_ok_q    <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      cnt_q     <= '0;
      go_read_q <= 1'b0;
    end else if (stop_det | tx_coll) begin
      state_q     <= ST_IDLE;
      lo_expect_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            rx_sr_q <= {rx_sr_q[BYTE_W-2:0], sda_sync_q[1]};
            cnt_q   <= cnt_q + 4'h1;
          end
          if (eighth_fall) begin
            is_addr_q  <= state_q == ST_ADDR;
            low_miss_q <= (state_q == ST_ADDR) & i_ten_bit_mode & lo_expect_q & !m10_lo;
            hold_q     <= load_buf & hold_now;
            ack_q      <= load_buf;
            go_read_q  <= (state_q == ST_ADDR) & byte_rw & !lo_expect_q;
            if (state_q == ST_ADDR & !addr_match & !(i_ten_bit_mode & lo_expect_q))
              state_q <= ST_IDLE;
            else
              state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (hold_q & !ckp_q)
            ack_q <= ~i_ack_value_select;
          if (ninth_fall) begin
            cnt_q <= '0;
            // A missed low byte also returns to high-byte matching
            if (is_addr_q & i_ten_bit_mode & (ack_q | low_miss_q) & !go_read_q)
              lo_expect_q <= !lo_expect_q;
            if (is_addr_q & i_ten_bit_mode & lo_expect_q)
              ten_ok_q <= ack_q;
            if (!ack_q)
              state_q <= ST_IDLE;
            else if (go_read_q)
              state_q <= ST_TX;
            else if (is_addr_q & i_ten_bit_mode & !lo_expect_q)
              state_q <= ST_ADDR;
            else
              state_q <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == BITS_PER_BYTE - 4'h1)
              state_q <= ST_TXACK;
          end
        end
        ST_TXACK: begin
          if (scl_fall) begin
            cnt_q   <= '0;
            state_q <= sda_sync_q[2] ? ST_IDLE : ST_TX;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Transmit shift register: loaded by a buffer write, shifted on SCL falls
  always_ff @(posedge i_clk) begin
    if (i_rst)
      tx_sr_q <= BYTE_RESET;
    else if (i_buffer_write)
      tx_sr_q <= i_buffer_wdata;
    else if (scl_fall & (state_q == ST_TX))
      tx_sr_q <= {tx_sr_q[BYTE_W-2:0], 1'b1};
  end

  // Buffer, full and overflow flags; hardware set wins over software clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      buf_q <= BYTE_RESET;
      bf_q  <= 1'b0;
      ov_q  <= 1'b0;
    end else begin
      if (load_buf)
        buf_q <= rx_sr_q;
      else if (i_buffer_write)
        buf_q <= i_buffer_wdata;
      if (load_buf | i_buffer_write)
        bf_q <= 1'b1;
      else if (i_buffer_read |
               (scl_fall & (state_q == ST_TX) & (cnt_q == BITS_PER_BYTE - 4'h1)))
        bf_q <= 1'b0;
      if (eighth_fall & (state_q == ST_RX) & bf_q)
        ov_q <= 1'b1;
      else if (i_overflow_clear)
        ov_q <= 1'b0;
    end
  end

  // Interrupt flag: only software clears it, a same-cycle set wins
  always_ff @(posedge i_clk) begin
    if (i_rst)
      pif_q <= 1'b0;
    else if (hw_set_if)
      pif_q <= 1'b1;
    else if (i_port_interrupt_clear)
      pif_q <= 1'b0;
  end

  // Release bit: hardware clear, software set
  always_ff @(posedge i_clk) begin
    if (i_rst)
      ckp_q <= RELEASE_RESET;
    else if (hw_clr_ckp)
      ckp_q <= 1'b0;
    else if (i_clock_release_set)
      ckp_q <= 1'b1;
  end

  // Status bits: ack time, read/write, ack received, stop, collision
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ackt_q  <= 1'b0;
      rw_q    <= 1'b0;
      ackst_q <= 1'b0;
      stop_q  <= 1'b0;
      bcl_q   <= 1'b0;
    end else begin
      if (eighth_fall & load_buf & hold_now)
        ackt_q <= 1'b1;
      else if (ninth_fall | start_det | stop_det)
        ackt_q <= 1'b0;
      if (eighth_fall & (state_q == ST_ADDR) & addr_match)
        rw_q <= byte_rw & !lo_expect_q;
      if (scl_rise & (state_q == ST_TXACK))
        ackst_q <= sda_sync_q[1];
      if (stop_det)
        stop_q <= 1'b1;
      else if (i_stop_clear | start_det)
        stop_q <= 1'b0;
      if (tx_coll)
        bcl_q <= 1'b1;
      else if (i_collision_clear)
        bcl_q <= 1'b0;
    end
  end

  // Address register and update flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q <= ADDR_RESET;
      ua_q   <= 1'b0;
    end else begin
      if (i_address_write)
        addr_q <= i_address_wdata;
      if (ninth_fall & is_addr_q & i_ten_bit_mode & !go_read_q & (ack_q | low_miss_q))
        ua_q <= 1'b1;
      else if (i_address_write)
        ua_q <= 1'b0;
    end
  end

  // SCL stretch only engages once SCL is already low
  always_ff @(posedge i_clk) begin
    if (i_rst)
      scl_oe_q <= 1'b0;
    else
      scl_oe_q <= (~ckp_q | ua_q) & (scl_oe_q | ~scl_sync_q[1]);
  end

  // SDA drive: ack slot or transmit zeros
  always_ff @(posedge i_clk) begin
    if (i_rst)
      sda_oe_q <= 1'b0;
    else
      sda_oe_q <= (state_q == ST_ACK & ack_q & (!hold_q | ckp_q)) |
                  (state_q == ST_TX & !tx_sr_q[BYTE_W-1] & !tx_coll);
  end

  // Registered outputs; SCL and SDA drive values tied low
  assign o_scl_o                    = 1'b0;
  assign o_sda_o                    = 1'b0;
  assign o_scl_oe                   = scl_oe_q;
  assign o_sda_oe                   = sda_oe_q;
  assign o_transfer_buffer          = buf_q;
  assign o_slave_address_register   = addr_q;
  assign o_buffer_full_flag         = bf_q;
  assign o_receive_overflow_flag    = ov_q;
  assign o_port_interrupt_flag      = pif_q;
  assign o_clock_release_bit        = ckp_q;
  assign o_ack_time_flag            = ackt_q;
  assign o_ack_received_status      = ackst_q;
  assign o_address_update_flag      = ua_q;
  assign o_collision_interrupt_flag = bcl_q;
  assign o_read_write_status        = rw_q;
  assign o_stop_detected            = stop_q;
endmodule
`default_nettype wire

// ### testbench/i2csh_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
module i2csh_chk (
  input wire logic                         i_clk,
  input wire logic                         i_rst,
  input wire logic                         i_scl,
  input wire logic                         i_stop_int_enable,
  input wire logic                         i_port_interrupt_clear,
  input wire logic                         i_buffer_read,
  input wire logic                         i_buffer_write,
  input wire logic [i2csh_pkg::BYTE_W-1:0] i_buffer_wdata,
  input wire logic                         o_scl_oe,
  input wire logic [i2csh_pkg::BYTE_W-1:0] o_transfer_buffer,
  input wire logic                         o_buffer_full_flag,
  input wire logic                         o_port_interrupt_flag,
  input wire logic                         o_clock_release_bit,
  input wire logic                         o_ack_received_status,
  input wire logic                         o_address_update_flag
);
  import i2csh_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Flag bookkeeping and bus timing relations
  property p_sticky; $fell(o_port_interrupt_flag) |-> $past(i_port_interrupt_clear); endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped alone");
  property p_rd; i_buffer_read && !i_buffer_write |=> !o_buffer_full_flag; endproperty
  a_rd: assert property (p_rd) else $error("buffer read kept full flag");
  property p_wr; i_buffer_write |=> o_transfer_buffer == $past(i_buffer_wdata); endproperty
  a_wr: assert property (p_wr) else $error("buffer write lost");
  property p_late; $rose(o_scl_oe) |-> !$past(i_scl); endproperty
  a_late: assert property (p_late) else $error("clock pulled while high");
  property p_free; (o_clock_release_bit && !o_address_update_flag) [*3] |-> !o_scl_oe; endproperty
  a_free: assert property (p_free) else $error("clock held after release");
  property p_hold; $fell(o_clock_release_bit) |-> ##[0:6] o_scl_oe; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_ackr; $changed(o_ack_received_status) |-> $past(i_scl, 2); endproperty
  a_ackr: assert property (p_ackr) else $error("ack status off the rise");
  property p_low; $rose(o_port_interrupt_flag) && !i_stop_int_enable |-> !$past(i_scl, 2); endproperty
  a_low: assert property (p_low) else $error("interrupt off a fall");
endmodule
bind i2csh_slave i2csh_chk u_chk (.i_clk, .i_rst, .i_scl, .i_stop_int_enable,
  .i_port_interrupt_clear, .i_buffer_read, .i_buffer_write, .i_buffer_wdata, .o_scl_oe,
  .o_transfer_buffer, .o_buffer_full_flag, .o_port_interrupt_flag, .o_clock_release_bit,
  .o_ack_received_status, .o_address_update_flag);
`default_nettype wire

// ### testbench/i2csh_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2csh_master (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var logic  o_scl_low,
  output var logic  o_sda_low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // Let SCL go and wait while a slave stretches it
  task automatic scl_high();
    int n;
    o_scl_low = 1'b0;
    for (n = 0; n < 5000 && i_scl !== 1'b1; n++) #20;
    #40;
  endtask
  // Data moves a quarter into the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    #20 o_sda_low = !b;
    #60 scl_high();
    s = i_sda;
    #40 o_scl_low = 1'b1;
  endtask
  task automatic start();
    o_sda_low = 1'b1;
    #80 o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #20 o_sda_low = 1'b1;
    #60 scl_high();
    #40 o_sda_low = 1'b0;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    int i;
    logic s;
    for (i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    int i;
    logic s;
    for (i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_i2csh_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2csh_slave;
  import i2csh_pkg::*;
  localparam logic [7:0] REL = 8'h01, ICLR = 8'h02, CCLR = 8'h04, OCLR = 8'h08, PCLR = 8'h10;
  localparam logic [7:0] RD = 8'h20, WR = 8'h40, AW = 8'h80;
  logic       i_clk, i_rst, ahe, dhe, se, ack_sel, ack, m_scl, m_sda;
  logic       scl_oe, sda_oe, bf, ovf, intf, rel, atim, ackrx, rws, stopd;
  logic       tbm, cde, sie, ua, bcl;
  logic [7:0] sw_q, wdata, rd, tbuf, sadr, adr;
  int         err_total, n_tests, cyc, i;
  wire        scl = !(m_scl | scl_oe);
  wire        sda = !(m_sda | sda_oe);
  i2csh_master m (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));
  i2csh_slave DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe),
    .o_sda_o(), .o_sda_oe(sda_oe), .i_ten_bit_mode(tbm), .i_address_hold_enable(ahe),
    .i_data_hold_enable(dhe), .i_stretch_enable(se), .i_slave_collision_detect_enable(cde),
    .i_stop_int_enable(sie), .i_ack_value_select(ack_sel), .i_clock_release_set(sw_q[0]),
    .i_port_interrupt_clear(sw_q[1]), .i_collision_clear(sw_q[2]), .i_overflow_clear(sw_q[3]),
    .i_stop_clear(sw_q[4]), .i_buffer_read(sw_q[5]), .i_buffer_write(sw_q[6]),
    .i_buffer_wdata(wdata), .i_address_write(sw_q[7]), .i_address_wdata(adr),
    .o_transfer_buffer(tbuf), .o_slave_address_register(sadr), .o_buffer_full_flag(bf),
    .o_receive_overflow_flag(ovf), .o_port_interrupt_flag(intf), .o_clock_release_bit(rel),
    .o_ack_time_flag(atim), .o_ack_received_status(ackrx), .o_address_update_flag(ua),
    .o_collision_interrupt_flag(bcl), .o_read_write_status(rws), .o_stop_detected(stopd)
  );
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  // Byte and flag comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Software strobes, one cycle wide
  task automatic sw(input logic [7:0] s);
    @(negedge i_clk) sw_q = s;
    @(negedge i_clk) sw_q = 8'h00;
  endtask
  task automatic wait_int();
    int n;
    for (n = 0; n < 3000 && intf !== 1'b1; n++) @(negedge i_clk);
    chk1(intf, 1'b1);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {ahe, dhe, se, ack_sel, tbm, cde, sie, sw_q, wdata, adr, err_total, n_tests, cyc} = '0;
    i_rst = 1'b1;
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    chk1(rel, 1'b1);
    chk1(bf, 1'b0);
    adr = 8'hA0;
    sw(AW);
    chk8(sadr, 8'hA0);
    // Address and data hold on a write, data byte refused by software
    {ahe, dhe} = 2'b11;
    m.start();
    fork
      m.wr_byte(8'hA0, ack);
      begin
        wait_int();
        chk1(rel, 1'b0);
        chk1(atim, 1'b1);
        chk8(tbuf, 8'hA0);
        sw(ICLR | RD);
        chk1(bf, 1'b0);
        sw(REL);
      end
    join
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(intf, 1'b1);
    sw(ICLR);
    fork
      m.wr_byte(8'h3C, ack);
      begin
        wait_int();
        chk1(rel, 1'b0);
        chk8(tbuf, 8'h3C);
        ack_sel = 1'b1;
        sw(ICLR | RD | REL);
      end
    join
    chk1(ack, 1'b1);
    repeat (6) @(negedge i_clk);
    chk1(intf, 1'b0);
    m.stop();
    repeat (6) @(negedge i_clk);
    chk1(stopd, 1'b1);
    chk1(intf, 1'b0);
    {ahe, dhe, ack_sel, se} = 4'b0001;
    sw(PCLR);
    $display("hold test done");
    // Stretch after address, data byte arrives on a full buffer
    m.start();
    m.wr_byte(8'hA0, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(rel, 1'b0);
    sw(ICLR | REL);
    m.wr_byte(8'h11, ack);
    chk1(ack, 1'b1);
    repeat (6) @(negedge i_clk);
    chk1(ovf, 1'b1);
    sw(OCLR | RD | ICLR);
    m.stop();
    repeat (6) @(negedge i_clk);
    se = 1'b0;
    $display("stretch test done");
    // Read: first byte acked, last byte nacked
    m.start();
    m.wr_byte(8'hA1, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(rws, 1'b1);
    chk8(tbuf, 8'hA1);
    chk1(rel, 1'b0);
    sw(ICLR | RD);
    for (i = 0; i < 2; i++) begin
      wdata = (i == 1) ? 8'h5A : 8'h96;
      sw(WR);
      sw(REL);
      m.rd_byte(i[0], rd);
      chk8(rd, wdata);
      chk1(ackrx, i[0]);
      repeat (6) @(negedge i_clk);
      chk1(intf, 1'b1);
      chk1(rel, i[0]);
      sw(ICLR);
    end
    m.stop();
    $display("read test done");
    // 10-bit write: high byte, address update, low byte, then a stretched data byte
    {tbm, adr} = {1'b1, 8'hF4};
    sw(AW);
    m.start();
    m.wr_byte(8'hF4, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(ua, 1'b1);
    chk1(intf, 1'b1);
    chk1(rel, 1'b1);
    adr = 8'hA5;
    sw(ICLR | RD | AW);
    chk1(ua, 1'b0);
    m.wr_byte(8'hA5, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(ua, 1'b1);
    chk8(tbuf, 8'hA5);
    {se, adr} = {1'b1, 8'hF4};
    sw(ICLR | RD | AW);
    m.wr_byte(8'h77, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    chk1(rel, 1'b0);
    chk8(tbuf, 8'h77);
    sw(ICLR | RD | REL);
    sie = 1'b1;
    m.stop();
    repeat (6) @(negedge i_clk);
    chk1(intf, 1'b1);
    sw(ICLR | PCLR);
    {sie, se} = 2'b00;
    // Low address byte that does not match
    m.start();
    m.wr_byte(8'hF4, ack);
    repeat (6) @(negedge i_clk);
    adr = 8'hA5;
    sw(ICLR | RD | AW);
    m.wr_byte(8'h5A, ack);
    chk1(ack, 1'b1);
    repeat (6) @(negedge i_clk);
    chk1(intf, 1'b1);
    chk1(ua, 1'b1);
    chk1(bf, 1'b0);
    chk1(rel, 1'b1);
    adr = 8'hF4;
    sw(ICLR | AW);
    m.stop();
    {tbm, cde, adr} = {2'b01, 8'hA0};
    sw(AW);
    $display("ten-bit test done");
    // Read with collision detect: master pulls SDA low under a released one bit
    m.start();
    m.wr_byte(8'hA1, ack);
    chk1(ack, 1'b0);
    repeat (6) @(negedge i_clk);
    wdata = 8'hFF;
    sw(ICLR | RD);
    sw(WR);
    sw(REL);
    m.wr_byte(8'h00, ack);
    repeat (6) @(negedge i_clk);
    chk1(bcl, 1'b1);
    chk1(rel, 1'b1);
    sw(CCLR | RD);
    chk1(bcl, 1'b0);
    m.stop();
    $display("collision test done");
    finish_test();
  end
endmodule
`default_nettype wire
